// [rtl/sckms_div.sv]
// Purpose: free-running prescaler giving one-cycle enables at 1/2..1/32
// Assumes: single clock domain
// Notes: en[k] pulses once every 2^(k+1) cycles
`timescale 1ns/100ps
module sckms_div
    import sckms_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // enables
    output logic [SCKMS_DIVW-1:0] en
);
    logic [SCKMS_DIVW-1:0] cnt_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // stage k fires when the low k+1 bits are all ones
    always_comb begin
        for (int k = 0; k < SCKMS_DIVW; k++) begin
            en[k] = &(cnt_q | ~((5'h02 << k) - 5'h01));
        end
    end
endmodule : sckms_div

// [rtl/sckms_pkg.sv]
// Purpose: constants for the system clock and module stop block
// Assumes: byte-wide register port, 16-bit byte addresses
// Notes: offsets are byte addresses
package sckms_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] SCKMS_ADDR_CLKCTL = 16'hFF3A;
    localparam logic [15:0] SCKMS_ADDR_MODE = 16'hFF3B;
    localparam logic [15:0] SCKMS_ADDR_STOPH = 16'hFF3C;
    localparam logic [15:0] SCKMS_ADDR_STOPL = 16'hFF3D;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SCKMS_BIT_CKOFF = 7;
    localparam int SCKMS_BIT_RSV6 = 6;
    localparam int SCKMS_BIT_DIV = 5;
    localparam logic [7:0] SCKMS_CLKCTL_WMASK = 8'hE7;
    localparam logic [7:0] SCKMS_RST_CLKCTL = 8'h00;
    localparam logic [15:0] SCKMS_RST_STOP = 16'h0000;
    localparam logic [15:0] SCKMS_STOP_USED = 16'h7666;
    localparam int SCKMS_BIT_XFER = 14;
    localparam int SCKMS_BIT_PTU = 13;
    localparam int SCKMS_BIT_TMR8 = 12;
    localparam int SCKMS_BIT_DAC = 10;
    localparam int SCKMS_BIT_ADC = 9;
    localparam int SCKMS_BIT_SER1 = 6;
    localparam int SCKMS_BIT_SER0 = 5;
    localparam int SCKMS_DIVW = 5;
    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCKMS_PWR_NORMAL = 2'h0,
        SCKMS_PWR_SLEEP = 2'h1,
        SCKMS_PWR_SWSTBY = 2'h2,
        SCKMS_PWR_HWSTBY = 2'h3
    } sckms_pwr_t;
endpackage : sckms_pkg

// [rtl/sckms_top.sv]
// Purpose: system clock select, clock pin control and module stop bits
// Assumes: byte register port on mclk, mode pins are asynchronous
// Notes: clock slow-down is delivered as one-cycle enables
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module sckms_top
    import sckms_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power state and mode pins
    input wire logic [1:0] pwr_state,
    input wire logic [2:0] mode_pins,
    // clock enables
    output logic master_clk_en,
    output logic chip_clk_en,
    // clock output pin
    output logic clk_pin_out,
    output logic clk_pin_oe_n,
    // module stop outputs
    output logic stop_transfer_ctrl,
    output logic stop_pulse_timer,
    output logic stop_byte_timer,
    output logic stop_dac,
    output logic stop_adc,
    output logic stop_serial_ch1,
    output logic stop_serial_ch0
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] clkctl_q;
    logic [15:0] stop_q;
    logic [2:0] mode_s1_q;
    logic [2:0] mode_s2_q;
    logic [7:0] rdata_q;
    logic [SCKMS_DIVW-1:0] div_en;
    logic [2:0] sel;
    logic div_whole;
    logic sel_en;
    logic clk_pin_q;
    logic clk_pin_oe_n_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clkctl_q <= SCKMS_RST_CLKCTL;
        end else if (reg_wr && reg_addr == SCKMS_ADDR_CLKCTL) begin
            clkctl_q <= reg_wdata & SCKMS_CLKCTL_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stop_q <= SCKMS_RST_STOP;
        end else if (reg_wr && reg_addr == SCKMS_ADDR_STOPH) begin
            stop_q[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == SCKMS_ADDR_STOPL) begin
            stop_q[7:0] <= reg_wdata;
        end
    end

    // mode pins pass two flops before use
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_s1_q <= 3'h0;
            mode_s2_q <= 3'h0;
        end else begin
            mode_s1_q <= mode_pins;
            mode_s2_q <= mode_s1_q;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                SCKMS_ADDR_CLKCTL: rdata_q <= clkctl_q;
                SCKMS_ADDR_MODE: rdata_q <= {5'h00, mode_s2_q};
                SCKMS_ADDR_STOPH: rdata_q <= stop_q[15:8];
                SCKMS_ADDR_STOPL: rdata_q <= stop_q[7:0];
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // clock division
    // ------------------------------------------------------------
    sckms_div u_div (
        .mclk(mclk),
        .rstn(rstn),
        .en(div_en)
    );

    assign sel = clkctl_q[2:0];
    assign div_whole = clkctl_q[SCKMS_BIT_DIV];

    always_comb begin
        sel_en = 1'b1;
        if (!div_whole) begin
            if (sel >= 3'h1 && sel <= 3'h5) begin
                sel_en = div_en[sel - 3'h1];
            end
        end else if (sel >= 3'h1 && sel <= 3'h3) begin
            sel_en = div_en[sel - 3'h1];
        end
        // other codes are undefined and fall back to full speed
    end

    assign master_clk_en = sel_en;
    assign chip_clk_en = div_whole ? sel_en : 1'b1;

    // ------------------------------------------------------------
    // clock pin: pulse high on chip enable, low otherwise; held high when CKOFF is set or in software standby, not driven in hardware standby
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clk_pin_q <= 1'b1;
            clk_pin_oe_n_q <= 1'b0;
        end else begin
            clk_pin_oe_n_q <= (pwr_state == SCKMS_PWR_HWSTBY);
            if (pwr_state == SCKMS_PWR_NORMAL
                || pwr_state == SCKMS_PWR_SLEEP) begin
                clk_pin_q <= clkctl_q[SCKMS_BIT_CKOFF] | chip_clk_en;
            end else begin
                clk_pin_q <= 1'b1;
            end
        end
    end
    assign clk_pin_out = clk_pin_q;
    assign clk_pin_oe_n = clk_pin_oe_n_q;

    // ------------------------------------------------------------
    // module stop outputs
    // ------------------------------------------------------------
    assign stop_transfer_ctrl = stop_q[SCKMS_BIT_XFER];
    assign stop_pulse_timer = stop_q[SCKMS_BIT_PTU];
    assign stop_byte_timer = stop_q[SCKMS_BIT_TMR8];
    assign stop_dac = stop_q[SCKMS_BIT_DAC];
    assign stop_adc = stop_q[SCKMS_BIT_ADC];
    assign stop_serial_ch1 = stop_q[SCKMS_BIT_SER1];
    assign stop_serial_ch0 = stop_q[SCKMS_BIT_SER0];
endmodule : sckms_top

// [verif/sckms_props.sv]
// Purpose: assertions on clock enables, clock pin and read data
// Assumes: ctl_q shadows writes to the clock control register
// Notes: bound into sckms_top
`timescale 1ns/100ps
module sckms_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // power state and clock outputs
    input wire logic [1:0] pwr_state,
    input wire logic master_clk_en,
    input wire logic chip_clk_en,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe_n
);
    logic [7:0] ctl_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            ctl_q <= 8'h00;
        else if (reg_wr && reg_addr == 16'hFF3A)
            ctl_q <= reg_wdata;
    end
    sequence s_gap3;
        !master_clk_en [*3] ##1 master_clk_en;
    endsequence
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_full_speed: assert property (
        ctl_q[2:0] == 3'h0 |-> master_clk_en && chip_clk_en)
        else $error("full speed enable low");
    a_half_rate: assert property (
        ctl_q[2:0] == 3'h1 && master_clk_en |=> !master_clk_en)
        else $error("half rate enable twice");
    a_quarter_gap: assert property (
        disable iff (!rstn || reg_wr)
        !reg_wr && ctl_q[2:0] == 3'h2 && master_clk_en |=> s_gap3)
        else $error("quarter rate spacing wrong");
    a_chip_whole: assert property (
        !ctl_q[5] |-> chip_clk_en) else $error("chip slowed");
    a_chip_div: assert property (
        ctl_q[5] |-> chip_clk_en == master_clk_en)
        else $error("chip enable differs");
    a_pin_high: assert property (
        (ctl_q[7] || pwr_state == 2'h2) && pwr_state != 2'h3
        |=> clk_pin_out) else $error("clock pin not high");
    a_pin_hiz: assert property (
        pwr_state == 2'h3 |=> clk_pin_oe_n) else $error("pin driven");
    a_read_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
endmodule : sckms_props
bind sckms_top sckms_props u_props (.mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_state(pwr_state),
    .master_clk_en(master_clk_en), .chip_clk_en(chip_clk_en),
    .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n));

// [verif/sckms_tb_top.sv]
// Purpose: directed bench for clock select and module stop block
// Assumes: strobes change just after rising edges
// Notes: enables are counted over 64 cycles at falling edges
`timescale 1ns/100ps
module sckms_tb_top;
    logic mclk, rstn, reg_wr, reg_rd, master_clk_en, chip_clk_en;
    logic clk_pin_out, clk_pin_oe_n;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, nm, nc, np;
    logic [1:0] pwr_state;
    logic [2:0] mode_pins;
    wire [6:0] stp;
    int err_total, checks, cyc;
    sckms_top u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwr_state(pwr_state),
        .mode_pins(mode_pins), .master_clk_en(master_clk_en),
        .chip_clk_en(chip_clk_en), .clk_pin_out(clk_pin_out),
        .clk_pin_oe_n(clk_pin_oe_n), .stop_transfer_ctrl(stp[6]),
        .stop_pulse_timer(stp[5]), .stop_byte_timer(stp[4]),
        .stop_dac(stp[3]), .stop_adc(stp[2]),
        .stop_serial_ch1(stp[1]), .stop_serial_ch0(stp[0]));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(reg_rdata, e);
        @(posedge mclk);
    endtask : rd
    task automatic run64();
        nm = 8'h00;
        nc = 8'h00;
        np = 8'h00;
        @(posedge mclk);
        repeat (64) begin
            @(negedge mclk);
            nm += master_clk_en;
            nc += chip_clk_en;
            np += !clk_pin_out;
        end
        @(posedge mclk);
    endtask : run64
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(16'hFF3A, 8'h00);
        rd(16'hFF3D, 8'h00);
        wr(16'hFF3A, 8'hFB);
        rd(16'hFF3A, 8'hE3);
        wr(16'hFF3B, 8'hFF);
        rd(16'hFF3B, 8'h05);
        mode_pins <= 3'h2;
        wr(16'hFF3B, 8'h00);
        rd(16'hFF3B, 8'h02);
        wr(16'hFF3E, 8'hFF);
        rd(16'hFF3E, 8'h00);
    endtask : t_regs
    task automatic t_stops();
        logic [15:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 16'h0001 << i;
            wr(16'hFF3C, v[15:8]);
            wr(16'hFF3D, v[7:0]);
            chk({9'h000, stp}, {9'h000, v[14:12], v[10:9], v[6:5]});
            rd(16'hFF3C, v[15:8]);
            rd(16'hFF3D, v[7:0]);
        end
    endtask : t_stops
    task automatic t_div();
        for (int d = 0; d < 2; d++) begin
            for (int c = 0; c < 6; c++) begin
                if (d == 0 || c < 4) begin
                    wr(16'hFF3A, {2'h0, d[0], 2'h0, c[2:0]});
                    run64();
                    chk(nm, 8'h40 >> c);
                    chk(nc, d ? 8'h40 >> c : 8'h40);
                end
            end
        end
    endtask : t_div
    task automatic t_pin();
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                pwr_state <= s[1:0];
                wr(16'hFF3A, {p[0], 7'h21});
                run64();
                if (s < 3)
                    chk(np, (s < 2 && p == 0) ? 8'h20 : 8'h00);
                chk(clk_pin_oe_n, s == 3);
            end
        end
        pwr_state <= 2'h0;
    endtask : t_pin
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        pwr_state = 2'h0;
        mode_pins = 3'h5;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_stops();
        t_div();
        t_pin();
        final_report();
    end
endmodule : sckms_tb_top
